// ==== core/lsf_pkg.sv ====
/*
  shared constants for the scanned led frame timing link: command codes,
  configuration field positions, reset values and timing figures.
  assumes a 100 MHz system clock at both ends of the link.
*/
package lsf_pkg;
  // ****************************************
  // link word
  // ****************************************
  localparam int          REG_W     = 48;
  localparam int          OP_W      = 4;
  localparam int          WORD_W    = 1 + OP_W + REG_W;
  localparam int          SYNC_N    = 3;
  localparam logic [3:0]  OP_CFG0   = 4'h1;
  localparam logic [3:0]  OP_CFG1   = 4'h2;
  localparam logic [3:0]  OP_CFG2   = 4'h3;
  localparam logic [3:0]  OP_VSYNC  = 4'h4;
  localparam logic [3:0]  OP_GS     = 4'h5;
  localparam logic [3:0]  OP_READ   = 4'h6;

  // ****************************************
  // configuration fields
  // ****************************************
  localparam int          SCAN_LSB  = 0;
  localparam int          SCAN_W    = 6;
  localparam int          SUB_LSB   = 8;
  localparam int          SUB_W     = 6;
  localparam int          SEG_LSB   = 0;
  localparam int          SEG_W     = 10;
  localparam int          LSW_LSB   = 37;
  localparam int          LSW_W     = 4;
  localparam int          LSW_UNIT  = 40;
  localparam int          MUL_LSB   = 0;
  localparam int          MUL_W     = 4;
  localparam int          GSL_LSB   = 16;
  localparam int          GSV_LSB   = 0;
  localparam logic [47:0] CFG0_RST  = 48'h0000_0000_1F0F;
  localparam logic [47:0] CFG1_RST  = 48'h0060_0000_0200;
  localparam logic [47:0] CFG2_RST  = 48'h0000_0000_0006;
  localparam logic [1:0]  SEL_FAULT = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int          SYS_MHZ      = 100;
  localparam int          SCLK_MAX_MHZ = 25;
  localparam int          HALF_MIN     = (SYS_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int          PER_W        = 10;
endpackage : lsf_pkg

// ==== core/lsf_link_if.sv ====
/*
  three-wire continuous clock serial link between controller and driver.
  assumes both ends sit on the same board clock rate; no wire is two-way.
*/
`timescale 1ns/10ps
interface lsf_link_if;
  logic sclk;
  logic serial_in;
  logic serial_out;

  modport ctl (output sclk, output serial_in, input serial_out);
  modport dev (input sclk, input serial_in, output serial_out);
endinterface : lsf_link_if

// ==== core/lsf_dev.sv ====
/*
  driver end: receives link words on both serial clock edges, derives the
  grayscale tick from the serial clock, runs segment, line switch and
  sub-period timing, detects led faults and answers reads on serial_out.
  assumes a controller that keeps the serial clock running at all times.
*/
`timescale 1ns/10ps
// Behaviour
// - controller keeps serial clock toggling always
// - data taken on both edges, max 25 MHz
// - grayscale tick multiplied up from serial clock
// - grayscale up to 160 MHz, 16-bit pwm; ticks here cap at one per 100 MHz system clock
// - all writes enter serial_in, reads leave serial_out
// - sub-periods times segment clocks give full scale
// - frame is segments plus switches per line, sub-period
// - leftover frame time is blank with outputs off
// - open and short faults flagged, suppressed, readable
// - controller sends zero data to unused channels
// - line switch gclks from 4-bit field bits 40:37
// - first two registers apply at frame sync only
module lsf_dev #(
  parameter int LINES = 16,
  parameter int GS_W  = 16
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  lsf_link_if.dev          link,
  input  wire logic        led_open_in,
  input  wire logic        led_wshort_in,
  input  wire logic        led_short_in,
  output logic [5:0]       line_sel_out,
  output logic             line_en_out,
  output logic             chan_on_out,
  output logic             grayscale_clock_out,
  output logic             blank_out
);
  localparam int LW = $clog2(LINES);
  typedef enum logic [1:0] {LSF_BLANK, LSF_SEG, LSF_SW} lsf_scan_t;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] s1_reg, s2_reg, s3_reg, stab_reg;
  logic       sclk_prev_reg;
  logic       edge_w, rise_w, bit_w;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_reg        <= 5'h00;
      s2_reg        <= 5'h00;
      s3_reg        <= 5'h00;
      stab_reg      <= 5'h00;
      sclk_prev_reg <= 1'b0;
    end else begin
      s1_reg        <= {led_short_in, led_wshort_in, led_open_in, link.serial_in, link.sclk};
      s2_reg        <= s1_reg;
      s3_reg        <= s2_reg;
      // new level only once stages two and three agree
      stab_reg      <= (s2_reg & s3_reg) | (stab_reg & (s2_reg | s3_reg));
      sclk_prev_reg <= stab_reg[0];
    end
  end

  assign edge_w = stab_reg[0] ^ sclk_prev_reg;
  assign rise_w = stab_reg[0] & ~sclk_prev_reg;
  assign bit_w  = stab_reg[1];

  // ****************************************
  // receiver
  // ****************************************
  localparam int WORD_W_M2 = lsf_pkg::WORD_W - 2;
  logic                  rx_busy_reg;
  logic [5:0]            rx_cnt_reg;
  logic [WORD_W_M2:0]    rx_sh_reg;
  logic                  rx_done_reg;
  logic [WORD_W_M2:0]    word_w;

  assign word_w = {rx_sh_reg[WORD_W_M2-1:0], bit_w};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg  <= 6'h00;
      rx_sh_reg   <= '0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (edge_w) begin
        if (!rx_busy_reg) begin
          rx_busy_reg <= bit_w;
          rx_cnt_reg  <= 6'h00;
        end else begin
          rx_sh_reg  <= word_w;
          rx_cnt_reg <= rx_cnt_reg + 6'h01;
          if (rx_cnt_reg == 6'(WORD_W_M2)) begin
            rx_busy_reg <= 1'b0;
            rx_done_reg <= 1'b1;
          end
        end
      end
    end
  end

  logic [3:0]  op_w;
  logic [47:0] dat_w;
  assign op_w  = rx_sh_reg[WORD_W_M2 -: 4];
  assign dat_w = rx_sh_reg[47:0];

  // ****************************************
  // configuration and grayscale memory
  // ****************************************
  logic [47:0]     cfg0_st_reg, cfg1_st_reg, cfg0_reg, cfg1_reg, cfg2_reg;
  logic [GS_W-1:0] gs_mem [LINES];
  logic            vsync_w;

  assign vsync_w = rx_done_reg && (op_w == lsf_pkg::OP_VSYNC);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg0_st_reg <= lsf_pkg::CFG0_RST;
      cfg1_st_reg <= lsf_pkg::CFG1_RST;
      cfg0_reg    <= lsf_pkg::CFG0_RST;
      cfg1_reg    <= lsf_pkg::CFG1_RST;
      cfg2_reg    <= lsf_pkg::CFG2_RST;
    end else if (rx_done_reg) begin
      if (op_w == lsf_pkg::OP_CFG0) cfg0_st_reg <= dat_w;
      if (op_w == lsf_pkg::OP_CFG1) cfg1_st_reg <= dat_w;
      if (op_w == lsf_pkg::OP_CFG2) cfg2_reg <= dat_w;
      if (vsync_w) begin
        cfg0_reg <= cfg0_st_reg;
        cfg1_reg <= cfg1_st_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < LINES; i++) begin
        gs_mem[i] <= '0;
      end
    end else if (rx_done_reg && op_w == lsf_pkg::OP_GS) begin
      gs_mem[dat_w[lsf_pkg::GSL_LSB +: LW]] <= dat_w[lsf_pkg::GSV_LSB +: GS_W];
    end
  end

  // ****************************************
  // grayscale tick multiplier
  // ****************************************
  // at most one tick per system clock, so faster settings saturate
  localparam int PW = lsf_pkg::PER_W;
  logic [lsf_pkg::PER_W-1:0] per_cnt_reg, per_reg, acc_reg, acc_w, rem_w;
  logic                      tick_w;

  assign acc_w  = acc_reg + PW'(cfg2_reg[lsf_pkg::MUL_LSB +: lsf_pkg::MUL_W]);
  assign tick_w = (per_reg != '0) && (acc_w >= per_reg);
  assign rem_w  = acc_w - per_reg;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      per_cnt_reg <= '0;
      per_reg     <= '0;
      acc_reg     <= '0;
    end else begin
      // period of the free-running serial clock, in system cycles
      per_cnt_reg <= rise_w ? '0 : per_cnt_reg + 1'b1;
      if (rise_w) per_reg <= per_cnt_reg + 1'b1;
      if (!tick_w) acc_reg <= (per_reg == '0) ? '0 : acc_w;
      else acc_reg <= (rem_w >= per_reg) ? '0 : rem_w;
    end
  end

  // ****************************************
  // frame timing
  // ****************************************
  lsf_scan_t  st_reg;
  logic [15:0] pos_reg;
  logic [5:0]  line_reg, sub_reg;
  logic [5:0]  nline_w, nsub_w;
  logic [15:0] seg_last_w, sw_last_w, sw_len_w;

  assign nline_w    = cfg0_reg[lsf_pkg::SCAN_LSB +: lsf_pkg::SCAN_W];
  assign nsub_w     = cfg0_reg[lsf_pkg::SUB_LSB +: lsf_pkg::SUB_W];
  assign seg_last_w = (cfg1_reg[lsf_pkg::SEG_LSB +: lsf_pkg::SEG_W] == '0) ? 16'h0000 :
                      16'(cfg1_reg[lsf_pkg::SEG_LSB +: lsf_pkg::SEG_W]) - 16'h0001;
  assign sw_len_w   = 16'(cfg1_reg[lsf_pkg::LSW_LSB +: lsf_pkg::LSW_W] * lsf_pkg::LSW_UNIT);
  assign sw_last_w  = (sw_len_w == 16'h0000) ? 16'h0000 : sw_len_w - 16'h0001;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg   <= LSF_BLANK;
      pos_reg  <= 16'h0000;
      line_reg <= 6'h00;
      sub_reg  <= 6'h00;
    end else if (vsync_w) begin
      st_reg   <= LSF_SEG;
      pos_reg  <= 16'h0000;
      line_reg <= 6'h00;
      sub_reg  <= 6'h00;
    end else if (tick_w) begin
      case (st_reg)
        LSF_SEG: begin
          pos_reg <= (pos_reg == seg_last_w) ? 16'h0000 : pos_reg + 16'h0001;
          if (pos_reg == seg_last_w) st_reg <= LSF_SW;
        end
        LSF_SW: begin
          pos_reg <= (pos_reg == sw_last_w) ? 16'h0000 : pos_reg + 16'h0001;
          if (pos_reg == sw_last_w) begin
            if (line_reg == nline_w || line_reg == 6'(LINES - 1)) begin
              line_reg <= 6'h00;
              sub_reg  <= sub_reg + 6'h01;
              st_reg   <= (sub_reg == nsub_w) ? LSF_BLANK : LSF_SEG;
            end else begin
              line_reg <= line_reg + 6'h01;
              st_reg   <= LSF_SEG;
            end
          end
        end
        LSF_BLANK: st_reg <= LSF_BLANK;
        default:   st_reg <= LSF_BLANK;
      endcase
    end
  end

  // ****************************************
  // led faults and outputs
  // ****************************************
  logic [LINES-1:0] open_reg, wsh_reg, sh_reg, set_o_w, set_w_w, set_s_w, clr_w;
  logic [17:0]      slot_w;
  logic [LW-1:0]    li_w;
  logic             rd_w;

  assign li_w    = line_reg[LW-1:0];
  assign rd_w    = rx_done_reg && op_w == lsf_pkg::OP_READ && dat_w[1:0] == lsf_pkg::SEL_FAULT;
  assign clr_w   = rd_w ? '1 : '0;
  // segment clock index interleaved with the sub-period spreads the pwm
  assign slot_w  = 18'(pos_reg[9:0]) * (18'(nsub_w) + 18'h00001) + 18'(sub_reg);
  assign set_o_w = (chan_on_out && stab_reg[2]) ? (LINES'(1) << line_sel_out[LW-1:0]) : '0;
  assign set_w_w = (line_en_out && stab_reg[3]) ? (LINES'(1) << line_sel_out[LW-1:0]) : '0;
  assign set_s_w = (line_en_out && stab_reg[4]) ? (LINES'(1) << line_sel_out[LW-1:0]) : '0;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_reg <= '0;
      wsh_reg  <= '0;
      sh_reg   <= '0;
    end else begin
      // a fault seen in the clearing cycle survives the read
      open_reg <= (open_reg & ~clr_w) | set_o_w;
      wsh_reg  <= (wsh_reg & ~clr_w) | set_w_w;
      sh_reg   <= (sh_reg & ~clr_w) | set_s_w;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_sel_out <= 6'h00;
      line_en_out  <= 1'b0;
      chan_on_out  <= 1'b0;
      grayscale_clock_out     <= 1'b0;
      blank_out    <= 1'b1;
    end else begin
      line_sel_out <= line_reg;
      line_en_out  <= (st_reg == LSF_SEG) && !sh_reg[li_w] && !wsh_reg[li_w];
      chan_on_out  <= (st_reg == LSF_SEG) && !open_reg[li_w] && (slot_w < 18'(gs_mem[li_w]));
      grayscale_clock_out     <= tick_w;
      blank_out    <= (st_reg == LSF_BLANK);
    end
  end

  // ****************************************
  // read answer
  // ****************************************
  logic [48:0] tx_sh_reg;
  logic [5:0]  tx_cnt_reg;
  logic        serial_out_reg;
  logic [47:0] rd_val_w;

  always_comb begin
    case (dat_w[1:0])
      2'h0:    rd_val_w = cfg0_reg;
      2'h1:    rd_val_w = cfg1_reg;
      2'h2:    rd_val_w = cfg2_reg;
      default: rd_val_w = 48'({open_reg, wsh_reg, sh_reg});
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_sh_reg  <= '0;
      tx_cnt_reg <= 6'h00;
      serial_out_reg   <= 1'b0;
    end else if (rx_done_reg && op_w == lsf_pkg::OP_READ) begin
      tx_sh_reg  <= {1'b1, rd_val_w};
      tx_cnt_reg <= 6'h31;
    end else if (edge_w) begin
      serial_out_reg <= (tx_cnt_reg != 6'h00) && tx_sh_reg[48];
      if (tx_cnt_reg != 6'h00) begin
        tx_sh_reg  <= {tx_sh_reg[47:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg - 6'h01;
      end
    end
  end

  assign link.serial_out = serial_out_reg;
endmodule : lsf_dev

// ==== core/lsf_ctl.sv ====
/*
  controller end: makes the continuous serial clock by a divider, shifts
  command words out on serial_in and collects read answers from serial_out.
  assumes a driver end on the same 100 MHz clock rate.
*/
`timescale 1ns/10ps
module lsf_ctl #(
  parameter int HALF = 4
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  lsf_link_if.ctl          link,
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  cmd_op_in,
  input  wire logic [47:0] cmd_data_in,
  output logic             cmd_ready_out,
  output logic             rd_valid_out,
  output logic [47:0]      rd_data_out
);
  // never faster than the link allows
  localparam int H  = (HALF < lsf_pkg::HALF_MIN) ? lsf_pkg::HALF_MIN : HALF;
  localparam int WW = lsf_pkg::WORD_W;

  // ****************************************
  // clock divider and transmit
  // ****************************************
  logic [7:0]    div_reg;
  logic          sclk_reg, sin_reg, rd_wait_reg;
  logic [WW-1:0] tx_sh_reg;
  logic [5:0]    tx_cnt_reg;
  logic          take_w;

  assign take_w = cmd_valid_in && cmd_ready_out;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_reg  <= 8'h00;
      sclk_reg <= 1'b0;
    end else begin
      // free running, never gated by traffic
      div_reg <= (div_reg == 8'(H - 1)) ? 8'h00 : div_reg + 8'h01;
      if (div_reg == 8'(H - 1)) sclk_reg <= ~sclk_reg;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_sh_reg  <= '0;
      tx_cnt_reg <= 6'h00;
      sin_reg    <= 1'b0;
    end else if (take_w) begin
      tx_sh_reg  <= {1'b1, cmd_op_in, cmd_data_in};
      tx_cnt_reg <= 6'(WW);
    end else if (div_reg == 8'(H / 2 - 1)) begin
      // data moves mid-half so it is settled at both edges
      sin_reg <= (tx_cnt_reg != 6'h00) && tx_sh_reg[WW-1];
      if (tx_cnt_reg != 6'h00) begin
        tx_sh_reg  <= {tx_sh_reg[WW-2:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg - 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) cmd_ready_out <= 1'b0;
    else cmd_ready_out <= !take_w && tx_cnt_reg == 6'h00 && !rd_wait_reg
                          && !(cmd_ready_out == 1'b0 && rd_valid_out);
  end

  // ****************************************
  // read answer
  // ****************************************
  logic [2:0]  so_sh_reg;
  logic        so_reg, rx_on_reg;
  logic [7:0]  tmr_reg;
  logic [5:0]  rx_cnt_reg;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      so_sh_reg <= 3'h0;
      so_reg    <= 1'b0;
    end else begin
      so_sh_reg <= {so_sh_reg[1:0], link.serial_out};
      if (so_sh_reg[1] == so_sh_reg[2]) so_reg <= so_sh_reg[2];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_wait_reg  <= 1'b0;
      rx_on_reg    <= 1'b0;
      tmr_reg      <= 8'h00;
      rx_cnt_reg   <= 6'h00;
      rd_valid_out <= 1'b0;
      rd_data_out  <= 48'h0000_0000_0000;
    end else begin
      rd_valid_out <= 1'b0;
      if (take_w && cmd_op_in == lsf_pkg::OP_READ) rd_wait_reg <= 1'b1;
      if (rd_wait_reg && !rx_on_reg && so_reg) begin
        rx_on_reg  <= 1'b1;
        tmr_reg    <= 8'(H + H / 2 - 1);
        rx_cnt_reg <= 6'h30;
      end else if (rx_on_reg) begin
        tmr_reg <= (tmr_reg == 8'h00) ? 8'(H - 1) : tmr_reg - 8'h01;
        if (tmr_reg == 8'h00) begin
          rd_data_out <= {rd_data_out[46:0], so_reg};
          rx_cnt_reg  <= rx_cnt_reg - 6'h01;
          if (rx_cnt_reg == 6'h01) begin
            rx_on_reg    <= 1'b0;
            rd_wait_reg  <= 1'b0;
            rd_valid_out <= 1'b1;
          end
        end
      end
    end
  end

  assign link.sclk      = sclk_reg;
  assign link.serial_in = sin_reg;
endmodule : lsf_ctl

// ==== sim/lsf_link_checker.sv ====
/*
  concurrent checks on the serial link and on the driver frame outputs.
  assumes HALF=4 at the controller and one 100 MHz clock at both ends.
*/
`timescale 1ns/10ps
module lsf_link_checker #(
  parameter int HALF = 4
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       sclk,
  input  wire logic       serial_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [3:0] cmd_op_in,
  input  wire logic       cmd_ready_out,
  input  wire logic       rd_valid_out,
  input  wire logic [5:0] line_sel_out,
  input  wire logic       line_en_out,
  input  wire logic       chan_on_out,
  input  wire logic       blank_out
);
  // ****************************************
  // helper logic
  // ****************************************
  // 53 bits at 4 cycles each; slack covers load and settle cycles
  localparam int SEND_MIN = 200;
  localparam int SEND_MAX = 260;
  logic       sclk_q_reg;
  logic [3:0] same_cnt_reg;
  logic       take;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  assign take = cmd_valid_in && cmd_ready_out;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_q_reg   <= 1'b0;
      same_cnt_reg <= 4'h0;
    end else begin
      sclk_q_reg <= sclk;
      if (sclk != sclk_q_reg) begin
        same_cnt_reg <= 4'h0;
      end else if (same_cnt_reg != 4'hF) begin
        same_cnt_reg <= same_cnt_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_sclk_alive: assert property (same_cnt_reg <= 4'(HALF))
    else $error("serial clock stopped");
  a_sclk_half_len: assert property ($changed(sclk) |=> $stable(sclk)[*3])
    else $error("serial clock half period too short");
  a_data_mid_half: assert property ($changed(serial_in) |-> $stable(sclk))
    else $error("data changed on a clock edge");
  // ready returns while the last data bit still stands on the line
  a_idle_line_low: assert property (cmd_ready_out && $past(cmd_ready_out, 4) |-> !serial_in)
    else $error("data line not low while idle");
  a_busy_min_len: assert property (take |=> (!cmd_ready_out)[*8] ##190 !cmd_ready_out)
    else $error("ready returned before word sent");
  a_write_done: assert property (take && cmd_op_in != lsf_pkg::OP_READ |-> ##[SEND_MIN:SEND_MAX] cmd_ready_out)
    else $error("ready not back after write");
  a_read_pulse: assert property (rd_valid_out |-> !cmd_ready_out ##1 !rd_valid_out)
    else $error("read answer not a single pulse");
  a_blank_dark: assert property (blank_out && $past(blank_out) |-> !line_en_out && !chan_on_out)
    else $error("output active during blank");
  a_switch_gap: assert property ($fell(line_en_out) && !blank_out |=> (!line_en_out)[*8])
    else $error("line switch interval too short");
  a_line_steady: assert property (line_en_out && $past(line_en_out) |-> $stable(line_sel_out))
    else $error("line changed inside a segment");
endmodule : lsf_link_checker

// ==== sim/led_scan_frame_timing_test.sv ====
/*
  self-checking bench: controller and driver joined by the link interface,
  commands sent through the controller port, driver outputs watched.
  assumes HALF=4 and the package reset configuration.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module led_scan_frame_timing_test;
  // ****************************************
  // stimulus and monitors
  // ****************************************
  localparam int HALF = 4;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cmd_op = 4'h0;
  logic [47:0] cmd_data = 48'h0, rd_data, rv;
  logic        led_open = 1'b0, led_wshort = 1'b0, led_short = 1'b0;
  logic        cmd_ready, rd_valid, line_en, chan_on, grayscale_clock, blank, en_seen = 1'b0;
  logic [5:0]  line_sel;
  logic [3:0]  seen = 4'h0;
  int          num_errors = 0, num_checks = 0, gcnt = 0, g0;

  lsf_link_if lsf_link_if_inst ();
  lsf_dev lsf_dev_inst (.sys_clk_in(sys_clk), .rstn_in(rstn), .link(lsf_link_if_inst.dev), .led_open_in(led_open),
    .led_wshort_in(led_wshort), .led_short_in(led_short), .line_sel_out(line_sel), .line_en_out(line_en),
    .chan_on_out(chan_on), .grayscale_clock_out(grayscale_clock), .blank_out(blank));
  lsf_ctl #(.HALF(HALF)) lsf_ctl_inst (.sys_clk_in(sys_clk), .rstn_in(rstn), .link(lsf_link_if_inst.ctl),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  lsf_link_checker #(.HALF(HALF)) lsf_link_checker_inst (.sys_clk_in(sys_clk), .rstn_in(rstn),
    .sclk(lsf_link_if_inst.sclk), .serial_in(lsf_link_if_inst.serial_in), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_ready_out(cmd_ready), .rd_valid_out(rd_valid), .line_sel_out(line_sel),
    .line_en_out(line_en), .chan_on_out(chan_on), .blank_out(blank));

  always #5 sys_clk = ~sys_clk;

  // tick count read at falling edges, so edge-to-edge differences are exact
  always @(posedge sys_clk) begin
    gcnt <= gcnt + int'(grayscale_clock);
    if (chan_on) seen[line_sel[1:0]] <= 1'b1;
    if (line_en) en_seen <= 1'b1;
  end

  task automatic step(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : step

  task automatic send(input logic [3:0] op, input logic [47:0] d);
    int t;
    t = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    while (cmd_ready !== 1'b1 && t < 3000) begin
      @(negedge sys_clk);
      t++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    `CHK("taken", 1'b1, t < 3000)
  endtask : send

  task automatic rd(input logic [1:0] sel);
    int t;
    t = 0;
    send(lsf_pkg::OP_READ, {46'h0, sel});
    while (rd_valid !== 1'b1 && t < 3000) begin
      @(negedge sys_clk);
      t++;
    end
    rv = rd_data;
  endtask : rd

  task automatic wait_en(input logic v);
    int t;
    t = 0;
    while (line_en !== v && t < 3000) begin
      @(negedge sys_clk);
      t++;
    end
  endtask : wait_en

  // segment 10 ticks, switch field 1 assumed by the expectations
  task automatic frame(input int nl);
    int gr;
    int t;
    gr = 0;
    t = 0;
    send(lsf_pkg::OP_VSYNC, 48'h0);
    for (int i = 0; i < nl; i++) begin
      wait_en(1'b1);
      `CHK("line", 6'(i), line_sel)
      if (i == 1) `CHK("line period", 10 + lsf_pkg::LSW_UNIT, gcnt - gr)
      gr = gcnt;
      wait_en(1'b0);
      if (i == 0) `CHK("segment", 10, gcnt - gr)
    end
    while (blank !== 1'b1 && line_en !== 1'b1 && t < 3000) begin
      @(negedge sys_clk);
      t++;
    end
    `CHK("blank after frame", 1'b1, blank)
  endtask : frame

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    step(20);
    `CHK("reset blank", 1'b1, blank)
    `CHK("reset ready", 1'b0, cmd_ready)
    rstn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(2'(i));
      `CHK("cfg reset", (i == 0) ? lsf_pkg::CFG0_RST : (i == 1) ? lsf_pkg::CFG1_RST : lsf_pkg::CFG2_RST, rv)
    end
    // ends on 6 so the default rate is back for the frame tests
    for (int m = 3; m <= 6; m += 3) begin
      send(lsf_pkg::OP_CFG2, 48'(m));
      rd(2'h2);
      `CHK("mul", 48'(m), rv)
      while (lsf_link_if_inst.sclk !== 1'b0) step(1);
      while (lsf_link_if_inst.sclk !== 1'b1) step(1);
      g0 = gcnt;
      step(40 * 2 * HALF);
      `CHK("ticks", 40 * m, gcnt - g0)
    end
    send(lsf_pkg::OP_CFG0, 48'h0000_0000_0003);
    send(lsf_pkg::OP_CFG1, 48'h0020_0000_000A);
    send(lsf_pkg::OP_GS, 48'h0000_0000_0005);
    send(lsf_pkg::OP_GS, 48'h0000_0001_0000);
    send(lsf_pkg::OP_GS, 48'h0000_0002_FFFF);
    // staged value must not be active before frame sync
    rd(2'h0);
    `CHK("staged", 1'b1, blank)
    `CHK("staged cfg0", lsf_pkg::CFG0_RST, rv)
    seen = 4'h0;
    frame(4);
    `CHK("gs line0", 1'b1, seen[0])
    `CHK("gs line1", 1'b0, seen[1])
    `CHK("gs line2", 1'b1, seen[2])
    send(lsf_pkg::OP_CFG0, 48'h0000_0000_0001);
    led_open = 1'b1;
    frame(2);
    // the first lit segment is what reveals the open led
    seen = 4'h0;
    frame(2);
    led_open = 1'b0;
    `CHK("open dark", 1'b0, seen[0])
    rd(2'h3);
    `CHK("open flag", 1'b1, |rv[47:32])
    `CHK("no short", 16'h0, rv[15:0])
    rd(2'h3);
    `CHK("flags cleared", 48'h0, rv)
    en_seen = 1'b0;
    led_short = 1'b1;
    led_wshort = 1'b1;
    send(lsf_pkg::OP_VSYNC, 48'h0);
    step(600);
    // a short shows only while its line is on, so judge the second frame
    en_seen = 1'b0;
    send(lsf_pkg::OP_VSYNC, 48'h0);
    step(600);
    `CHK("shorted line off", 1'b0, en_seen)
    led_short = 1'b0;
    led_wshort = 1'b0;
    rd(2'h3);
    `CHK("short flags", 2'h3, {|rv[31:16], |rv[15:0]})
    give_verdict();
  end
endmodule : led_scan_frame_timing_test
